// ===== mmpd_consts.vh
// Purpose: offsets, fields and reset values of the gate and divider registers
// Assumes: 15-bit register address from the spi port decoder, 8-bit data
// Notes:   included by both design files
// How it works
// (R01) eight-bit silence gate register resets 0xbf
// (R02) one enables block silence; master is bit 7
// (R03) eight-bit power gate register resets all ones
// (R04) one enables block power; master is bit 7
// (R05) bit 0 silences on unlock; upper bits read zero
// (R06) sixteen-bit feedback word resets 0x0190
// (R07) whole feedback word applied on low write
// (R08) bit 1 prescaler, bit 0 feedback divider
// (R09) five-bit reference divisor resets one
// (R10) read-only lock status bit, one is locked
`ifndef MMPD_CONSTS_VH
`define MMPD_CONSTS_VH

// ****************************************
// offsets
// ****************************************
`define MMPD_ADDR_SILENCE   15'h0101
`define MMPD_ADDR_POWER     15'h0102
`define MMPD_ADDR_LOSS      15'h0103
`define MMPD_ADDR_FB_LOW    15'h0200
`define MMPD_ADDR_FB_HIGH   15'h0201
`define MMPD_ADDR_LOOP_CFG  15'h020b
`define MMPD_ADDR_REF_DIV   15'h020c
`define MMPD_ADDR_LOCK      15'h024d

// ****************************************
// reset values
// ****************************************
`define MMPD_RST_SILENCE    8'hbf
`define MMPD_RST_POWER      8'hff
`define MMPD_RST_LOSS       1'h1
`define MMPD_RST_FB_LOW     8'h90
`define MMPD_RST_FB_HIGH    8'h01
`define MMPD_RST_LOOP_CFG   2'h1
`define MMPD_RST_REF_DIV    5'h01

// ****************************************
// field positions
// ****************************************
`define MMPD_BIT_MASTER     7
`define MMPD_BIT_PRESCALER  1
`define MMPD_BIT_FBDIV      0
`define MMPD_BIT_LOSS       0
`define MMPD_REF_DIV_MSB    4

`endif

// ===== mmpd_fb_word.v
// Purpose: double buffer for the sixteen-bit feedback word
// Assumes: one write strobe per byte, same clock as the register file
// Notes:   high byte waits in a shadow until the low byte lands
`timescale 1ns/1ps
`include "mmpd_consts.vh"

module mmpd_fb_word (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    // byte writes
    input  wire        wr_low,
    input  wire        wr_high,
    input  wire [7:0]  wr_data,
    // buffered bytes and applied word
    output reg  [7:0]  buf_low,
    output reg  [7:0]  buf_high,
    output reg  [15:0] fb_word
);

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            buf_low  <= `MMPD_RST_FB_LOW;                       // (R06)
            buf_high <= `MMPD_RST_FB_HIGH;                      // (R06)
            fb_word  <= {`MMPD_RST_FB_HIGH, `MMPD_RST_FB_LOW};  // (R06)
        end
        else if (clk_en)
        begin
            if (wr_high)
                buf_high <= wr_data;
            if (wr_low)
            begin
                buf_low <= wr_data;
                // low write commits both bytes at once, never half-updated
                fb_word <= {buf_high, wr_data};                 // (R07)
            end
        end
    end

endmodule // mmpd_fb_word

// ===== mmpd_regs.v
// Purpose: gate masks, unlock silence and loop divider registers
// Assumes: spi framing outside; one-cycle read/write strobes on clk
// Notes:   unmapped reads return zero; lock input is a raw analog flag
//          feedback bytes read back the buffer, not the applied word
//          clk_en low freezes every flop, the synchroniser included
//          lock status reads at its own read-only offset
`timescale 1ns/1ps
`include "mmpd_consts.vh"

module mmpd_regs (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    // register port from spi decoder
    input  wire [14:0] reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // pll status pin
    input  wire        pll_lock_raw,
    // silence gates
    output wire        master_silence_gate,
    output wire        synthesizer_silence_gate,
    output wire        detector_silence_gate,
    output wire        output_switch_silence_gate,
    output wire        driver_amp_silence_gate,
    output wire        predriver_amp_silence_gate,
    output wire        oscillator_amp_silence_gate,
    output wire        input_amp_silence_gate,
    // power gates
    output wire [7:0]  power_gate,
    output wire        master_power_gate,
    output wire        input_amp_power_gate,
    // unlock silence
    output reg         unlock_silence,
    // synthesizer settings
    output wire [15:0] feedback_word,
    output wire        prescaler_enable,
    output wire        feedback_divider_enable,
    output wire [4:0]  reference_divide
);

    // ****************************************
    // decode
    // ****************************************
    function hit;
        input [14:0] a;
        input [14:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // register storage
    reg  [7:0]  silence_gate_select;
    reg  [7:0]  power_gate_select;
    reg         loop_loss_silence;
    reg  [1:0]  loop_divider_config;
    reg  [4:0]  reference_divisor;
    // feedback bytes live in the double buffer
    wire [7:0]  feedback_divisor_low;
    wire [7:0]  feedback_divisor_high;

    // frozen cycles drop writes as well
    wire        wr_en = reg_wr & clk_en;

    // ****************************************
    // write strobes
    // ****************************************
    // one strobe per register keeps wide compares off the flop enables
    wire        wr_silence  = wr_en & hit(reg_addr, `MMPD_ADDR_SILENCE);
    wire        wr_power    = wr_en & hit(reg_addr, `MMPD_ADDR_POWER);
    wire        wr_loss     = wr_en & hit(reg_addr, `MMPD_ADDR_LOSS);
    wire        wr_fb_low   = wr_en & hit(reg_addr, `MMPD_ADDR_FB_LOW);
    wire        wr_fb_high  = wr_en & hit(reg_addr, `MMPD_ADDR_FB_HIGH);
    wire        wr_loop_cfg = wr_en & hit(reg_addr, `MMPD_ADDR_LOOP_CFG);
    wire        wr_ref_div  = wr_en & hit(reg_addr, `MMPD_ADDR_REF_DIV);

    // ****************************************
    // lock synchroniser
    // ****************************************
    // analog flag crosses in; accept a change once stages two and three agree
    reg  [2:0]  lock_sync;
    reg         pll_locked;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            lock_sync <= 3'h0;
        else if (clk_en)
            lock_sync <= {lock_sync[1:0], pll_lock_raw};
    end

    // a one-cycle glitch never shows in both late stages at once
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pll_locked <= 1'b0;                                 // (R10)
        else if (clk_en && (lock_sync[2] == lock_sync[1]))
            pll_locked <= lock_sync[1];                         // (R10)
    end

    // ****************************************
    // control registers
    // ****************************************
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            silence_gate_select <= `MMPD_RST_SILENCE;           // (R01)
            power_gate_select   <= `MMPD_RST_POWER;             // (R03)
            loop_loss_silence   <= `MMPD_RST_LOSS;              // (R05)
            loop_divider_config <= `MMPD_RST_LOOP_CFG;          // (R08)
            reference_divisor   <= `MMPD_RST_REF_DIV;           // (R09)
        end
        else if (wr_en)
        begin
            if (wr_silence)
                silence_gate_select <= reg_wdata;               // (R01)
            if (wr_power)
                power_gate_select <= reg_wdata;                 // (R03)
            // upper bits are read-only, so writes to them drop
            if (wr_loss)
                loop_loss_silence <= reg_wdata[`MMPD_BIT_LOSS]; // (R05)
            if (wr_loop_cfg)
                loop_divider_config <= reg_wdata[1:0];          // (R08)
            if (wr_ref_div)
                reference_divisor <= reg_wdata[`MMPD_REF_DIV_MSB:0]; // (R09)
        end
    end

    // high byte waits in the buffer until the low byte commits
    mmpd_fb_word u_fb_word (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .wr_low   (wr_fb_low),
        .wr_high  (wr_fb_high),
        .wr_data  (reg_wdata),
        .buf_low  (feedback_divisor_low),
        .buf_high (feedback_divisor_high),
        .fb_word  (feedback_word)
    );                                                          // (R06)

    // ****************************************
    // unlock silence
    // ****************************************
    // registered so the analog mute never sees a decode glitch
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            unlock_silence <= 1'b0;
        else if (clk_en)
            unlock_silence <= loop_loss_silence & ~pll_locked;  // (R05)
    end

    // ****************************************
    // gate outputs
    // ****************************************
    assign master_silence_gate =
        silence_gate_select[`MMPD_BIT_MASTER];                  // (R02)
    assign synthesizer_silence_gate    = silence_gate_select[6]; // (R02)
    assign detector_silence_gate       = silence_gate_select[5]; // (R02)
    assign output_switch_silence_gate  = silence_gate_select[4]; // (R02)
    assign driver_amp_silence_gate     = silence_gate_select[3]; // (R02)
    assign predriver_amp_silence_gate  = silence_gate_select[2]; // (R02)
    assign oscillator_amp_silence_gate = silence_gate_select[1]; // (R02)
    assign input_amp_silence_gate      = silence_gate_select[0]; // (R02)

    // ****************************************
    // power gate outputs
    // ****************************************
    assign power_gate           = power_gate_select;            // (R04)
    assign master_power_gate    =
        power_gate_select[`MMPD_BIT_MASTER];                    // (R04)
    assign input_amp_power_gate = power_gate_select[0];         // (R04)

    // ****************************************
    // synthesizer settings
    // ****************************************
    assign prescaler_enable =
        loop_divider_config[`MMPD_BIT_PRESCALER];               // (R08)
    assign feedback_divider_enable =
        loop_divider_config[`MMPD_BIT_FBDIV];                   // (R08)
    assign reference_divide = reference_divisor;                // (R09)

    // ****************************************
    // read mux
    // ****************************************
    // read data held from flip-flops; reserved bits and holes read zero
    reg  [7:0]  next_rdata;

    always @*
    begin
        case (reg_addr)
            `MMPD_ADDR_SILENCE:  next_rdata = silence_gate_select;
            `MMPD_ADDR_POWER:    next_rdata = power_gate_select;
            `MMPD_ADDR_LOSS:     next_rdata = {7'h00, loop_loss_silence};
            `MMPD_ADDR_FB_LOW:   next_rdata = feedback_divisor_low;
            `MMPD_ADDR_FB_HIGH:  next_rdata = feedback_divisor_high;
            `MMPD_ADDR_LOOP_CFG: next_rdata = {6'h00, loop_divider_config};
            `MMPD_ADDR_REF_DIV:  next_rdata = {3'h0, reference_divisor};
            `MMPD_ADDR_LOCK:     next_rdata = {7'h00, pll_locked};   // (R10)
            default:             next_rdata = 8'h00;
        endcase
    end

    // a read and a write in one cycle return the old contents
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_rd)
            reg_rdata <= next_rdata;
    end

endmodule // mmpd_regs

// ===== mmpd_regs_checker.sv
// Purpose: port checks for the gate and divider registers
// Assumes: bound onto mmpd_regs; one clock domain
// Notes:   lock timing gets one cycle of slack
`timescale 1ns/1ps
module mmpd_regs_checker (
    // clock and reset
    input wire        clk,
    input wire        sys_rst,
    // register port
    input wire        clk_en,
    input wire [14:0] reg_addr,
    input wire        reg_wr,
    input wire [7:0]  reg_wdata,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // lock input and watched outputs
    input wire        pll_lock_raw,
    input wire        master_silence_gate,
    input wire        input_amp_silence_gate,
    input wire [7:0]  power_gate,
    input wire        master_power_gate,
    input wire        unlock_silence,
    input wire [15:0] feedback_word,
    input wire        prescaler_enable,
    input wire        feedback_divider_enable,
    input wire [4:0]  reference_divide
);
    wire wr_ok = reg_wr && clk_en;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ********
    // assertions
    // ********
    AST_SIL: assert property (wr_ok && reg_addr == 15'h101 |=>
        master_silence_gate == $past(reg_wdata[7]) &&
        input_amp_silence_gate == $past(reg_wdata[0])) else $error("silence");
    AST_PWR: assert property (wr_ok && reg_addr == 15'h102 |=>
        power_gate == $past(reg_wdata)) else $error("power gate");
    AST_PWR_MAP: assert property (master_power_gate == power_gate[7])
        else $error("master power bit");
    AST_PWR_HOLD: assert property (!(wr_ok && reg_addr == 15'h102) |=>
        $stable(power_gate)) else $error("power gate moved without write");
    AST_FB_LOW: assert property (wr_ok && reg_addr == 15'h200 |=>
        feedback_word[7:0] == $past(reg_wdata)) else $error("word low");
    AST_FB_HOLD: assert property (wr_ok && reg_addr == 15'h201 |=>
        $stable(feedback_word)) else $error("word half applied");
    AST_CFG: assert property (wr_ok && reg_addr == 15'h20b |=>
        {prescaler_enable, feedback_divider_enable} == $past(reg_wdata[1:0]))
        else $error("loop config");
    AST_REF: assert property (wr_ok && reg_addr == 15'h20c |=>
        reference_divide == $past(reg_wdata[4:0])) else $error("ref div");
    AST_LOCKED: assert property ((pll_lock_raw && clk_en) [*7] |->
        !unlock_silence) else $error("silenced while locked");
    AST_LOSS_OFF: assert property (wr_ok && reg_addr == 15'h103 &&
        !reg_wdata[0] |-> ##2 !unlock_silence) else $error("loss off");
    AST_RD_HOLD: assert property (!(reg_rd && clk_en) |=>
        $stable(reg_rdata)) else $error("read data moved");
endmodule // mmpd_regs_checker

// ===== mmpd_regs_tb.sv
// Purpose: self-checking bench for the gate and divider registers
// Assumes: lock filter settles within six cycles
// Notes:   table rows check reset value, then readback
`timescale 1ns/1ps
module mmpd_regs_tb;
    logic clk = 0, sys_rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic pll_lock_raw = 0;
    logic [14:0] reg_addr = 15'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    wire [7:0] reg_rdata, power_gate, sil;
    wire master_power_gate, input_amp_power_gate, unlock_silence;
    wire prescaler_enable, feedback_divider_enable;
    wire [15:0] feedback_word;
    wire [4:0] reference_divide;
    int bad_count = 0, n_compared = 0, i;
    // addr, reset value, write data, readback
    logic [38:0] rows [9] = '{
        {15'h101, 8'hbf, 8'ha5, 8'ha5},
        {15'h102, 8'hff, 8'h3c, 8'h3c},
        {15'h103, 8'h01, 8'hff, 8'h01},
        {15'h20b, 8'h01, 8'hff, 8'h03},
        {15'h20c, 8'h01, 8'hff, 8'h1f},
        {15'h201, 8'h01, 8'h12, 8'h12},
        {15'h200, 8'h90, 8'h34, 8'h34},
        {15'h24d, 8'h00, 8'hff, 8'h00},
        {15'h0ff, 8'h00, 8'h55, 8'h00}};
    mmpd_regs u_mmpd_regs (.*,
        .master_silence_gate(sil[7]), .synthesizer_silence_gate(sil[6]),
        .detector_silence_gate(sil[5]), .output_switch_silence_gate(sil[4]),
        .driver_amp_silence_gate(sil[3]), .predriver_amp_silence_gate(sil[2]),
        .oscillator_amp_silence_gate(sil[1]), .input_amp_silence_gate(sil[0]));
    initial forever #25 clk = ~clk;
    task chk(input string n, input [15:0] e, input [15:0] g);
        begin
            n_compared++;
            if (g !== e)
            begin
                bad_count++;
                $display("[FAIL] %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task wr(input [14:0] a, input [7:0] d);
        begin
            @(posedge clk);
            {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [14:0] a, input [7:0] e);
        begin
            @(posedge clk);
            {reg_addr, reg_rd} <= {a, 1'b1};
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk("reg_rdata", 16'(e), 16'(reg_rdata));
        end
    endtask
    task conclude;
        begin
            $display("compared %0d mismatched %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 9; i++)
        begin
            rd(rows[i][38:24], rows[i][23:16]);
            wr(rows[i][38:24], rows[i][15:8]);
            rd(rows[i][38:24], rows[i][7:0]);
        end
        chk("silence gates", 16'h00a5, 16'(sil));
        chk("power_gate", 16'h003c, 16'(power_gate));
        chk("feedback_word", 16'h1234, feedback_word);
        chk("loop cfg", 16'h0003, 16'({prescaler_enable,
            feedback_divider_enable}));
        chk("reference_divide", 16'h001f, 16'(reference_divide));
        chk("unlock_silence", 16'h0001, 16'(unlock_silence));
        chk("power gate ends", 16'h0000, 16'({master_power_gate,
            input_amp_power_gate}));
        $display("table and outputs done");
        wr(15'h201, 8'h56);
        @(posedge clk);
        #1 chk("feedback_word", 16'h1234, feedback_word);
        wr(15'h200, 8'h78);
        @(posedge clk);
        #1 chk("feedback_word", 16'h5678, feedback_word);
        $display("word buffering done");
        @(posedge clk);
        pll_lock_raw <= 1'b1;
        repeat (6) @(posedge clk);
        rd(15'h24d, 8'h01);
        chk("unlock_silence", 16'h0000, 16'(unlock_silence));
        @(posedge clk);
        pll_lock_raw <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk("unlock_silence", 16'h0001, 16'(unlock_silence));
        wr(15'h103, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("unlock_silence", 16'h0000, 16'(unlock_silence));
        $display("lock and silence done");
        @(posedge clk);
        clk_en <= 1'b0;
        wr(15'h101, 8'h00);
        clk_en <= 1'b1;
        rd(15'h101, 8'ha5);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(15'h101, 8'hbf);
        rd(15'h200, 8'h90);
        chk("feedback_word", 16'h0190, feedback_word);
        chk("silence gates", 16'h00bf, 16'(sil));
        chk("power gate ends", 16'h0003, 16'({master_power_gate,
            input_amp_power_gate}));
        $display("freeze and second reset done");
        conclude;
    end
endmodule // mmpd_regs_tb
bind mmpd_regs mmpd_regs_checker u_mmpd_regs_checker (.*);
